/* verilog/three_level_irq_handler.sv */
`timescale 1ns/1ps
`include "irq_defs.svh"

// Summary of operation
// - Twenty-four source inputs are split into three levels of eight sources each.
// - The high group drives processor level zero, mid level one, low level two.
// - Sources 16 to 23 sit in bits 0 to 7 of the high flag register, ascending.
// - Sources 8 to 15 sit in bits 0 to 7 of the mid flag register, ascending.
// - Sources 0 to 7 sit in bits 0 to 7 of the low flag register, ascending.
// - Writing a one to a flag bit clears it, and reads return the current flags.
// - Reset clears every flag bit of the three flag registers.
// - Three read-write enable registers hold one enable per source, reset to zero.
// - A read-only register holds the code of the top pending source, reset to all ones.
// - Summary bits 2, 1 and 0 show any high, mid and low flag pending, reset zero.
// - Summary bits 7 to 3 always read as zero.
// - A flag sets only on a rising source edge while its enable bit is one.
// - Writing a zero to a flag bit leaves it as it was.
// - Sources are sampled on the system clock and the level rises one cycle later.
// - The top code reads 0xFF whenever no flag is pending.
module three_level_irq_handler (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire irq_pkg::src_vec_t srcIn,
  input  wire irq_pkg::bus_req_t busReq,
  output logic [7:0]             busRdData,
  output logic                   cpuIntLevelZero,
  output logic                   cpuIntLevelOne,
  output logic                   cpuIntLevelTwo,
  output logic                   irqOut
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------

  // True when the request is the given kind of access to the given offset
  function automatic logic hit(input irq_pkg::bus_req_t req,
                               input irq_pkg::addr_t    ofs,
                               input logic              isWrite);
    hit = (isWrite ? req.wr : req.rd) && (req.addr == ofs);
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam irq_pkg::state_t STATE_RST = '{
    flags     : `IRQ_FLAGS_RST,
    enables   : `IRQ_EN_RST,
    srcPrev   : `IRQ_FLAGS_RST,
    topCode   : `IRQ_CODE_RST,
    summary   : `IRQ_SUM_RST,
    cpuInt    : `IRQ_SUM_RST,
    evtStatus : `IRQ_EVT_RST,
    evtMask   : `IRQ_EVT_RST,
    irqOut    : 1'b0,
    rdData    : `IRQ_RD_RST
  };

  irq_pkg::state_t    state_reg;
  irq_pkg::state_t    state_next;
  irq_pkg::src_vec_t  setVec;
  irq_pkg::src_vec_t  clrVec;
  irq_pkg::src_vec_t  flags_next;
  irq_pkg::level_vec_t anyNext;
  irq_pkg::level_vec_t groupNew;
  logic [7:0]         codeNext;

  // ----------------------------------------------------------------------
  // Edge detection and flag clearing
  // ----------------------------------------------------------------------

  // Inputs are synchronous, so one sample of history is enough for an edge
  assign setVec = srcIn & ~state_reg.srcPrev & state_reg.enables;

  // Clear mask per group, placed at each group's source numbers
  assign clrVec = {
    hit(busReq, `IRQ_HIGH_FLAGS_OFS, 1'b1) ? busReq.wrData : 8'h00,
    hit(busReq, `IRQ_MID_FLAGS_OFS, 1'b1)  ? busReq.wrData : 8'h00,
    hit(busReq, `IRQ_LOW_FLAGS_OFS, 1'b1)  ? busReq.wrData : 8'h00
  };

  // A zero in the write data keeps the flag; a new edge beats the clear
  assign flags_next = (state_reg.flags & ~clrVec) | setVec;

  // ----------------------------------------------------------------------
  // Per-group reduction
  // ----------------------------------------------------------------------

  // Index 0 is the low group, 2 the high group, matching the summary bits
  for (genvar g = 0; g < `IRQ_LEVELS; g++) begin : gGroup
    assign anyNext[g]  = |flags_next[g*`IRQ_GROUP_W +: `IRQ_GROUP_W];
    assign groupNew[g] = |(setVec[g*`IRQ_GROUP_W +: `IRQ_GROUP_W]
                          & ~state_reg.flags[g*`IRQ_GROUP_W +: `IRQ_GROUP_W]);
  end

  // Top pending code from the flags as they will stand after this edge
  pending_code_encoder #(
    .WIDTH (`IRQ_SOURCES)
  ) uEncoder (
    .pending (flags_next),
    .code    (codeNext)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.srcPrev = srcIn;
    state_next.flags = flags_next;
    // Derived values are registered from the next flags so they never lag them
    state_next.topCode = codeNext;
    state_next.summary = anyNext;
    state_next.cpuInt = {anyNext[0], anyNext[1], anyNext[2]};
    // Enable registers, one per group
    if (hit(busReq, `IRQ_HIGH_EN_OFS, 1'b1)) begin
      state_next.enables[`IRQ_HIGH_BASE +: `IRQ_GROUP_W] = busReq.wrData;
    end
    if (hit(busReq, `IRQ_MID_EN_OFS, 1'b1)) begin
      state_next.enables[`IRQ_MID_BASE +: `IRQ_GROUP_W] = busReq.wrData;
    end
    if (hit(busReq, `IRQ_LOW_EN_OFS, 1'b1)) begin
      state_next.enables[`IRQ_LOW_BASE +: `IRQ_GROUP_W] = busReq.wrData;
    end
    // Sticky group events; a new event in the clearing cycle survives
    state_next.evtStatus = state_reg.evtStatus | groupNew;
    if (hit(busReq, `IRQ_EVT_STATUS_OFS, 1'b1)) begin
      state_next.evtStatus = (state_reg.evtStatus & ~busReq.wrData[2:0]) | groupNew;
    end
    if (hit(busReq, `IRQ_EVT_MASK_OFS, 1'b1)) begin
      state_next.evtMask = busReq.wrData[2:0];
    end
    state_next.irqOut = |(state_next.evtStatus & state_next.evtMask);
    // Read data stand for exactly one cycle, zero otherwise
    state_next.rdData = 8'h00;
    if (busReq.rd) begin
      unique case (busReq.addr)
        `IRQ_HIGH_FLAGS_OFS: begin
          state_next.rdData = state_reg.flags[`IRQ_HIGH_BASE +: `IRQ_GROUP_W];
        end
        `IRQ_MID_FLAGS_OFS: begin
          state_next.rdData = state_reg.flags[`IRQ_MID_BASE +: `IRQ_GROUP_W];
        end
        `IRQ_LOW_FLAGS_OFS: begin
          state_next.rdData = state_reg.flags[`IRQ_LOW_BASE +: `IRQ_GROUP_W];
        end
        `IRQ_HIGH_EN_OFS: begin
          state_next.rdData = state_reg.enables[`IRQ_HIGH_BASE +: `IRQ_GROUP_W];
        end
        `IRQ_MID_EN_OFS: begin
          state_next.rdData = state_reg.enables[`IRQ_MID_BASE +: `IRQ_GROUP_W];
        end
        `IRQ_LOW_EN_OFS: begin
          state_next.rdData = state_reg.enables[`IRQ_LOW_BASE +: `IRQ_GROUP_W];
        end
        `IRQ_TOP_CODE_OFS: begin
          state_next.rdData = state_reg.topCode;
        end
        `IRQ_SUMMARY_OFS: begin
          state_next.rdData = {5'h00, state_reg.summary};
        end
        `IRQ_EVT_STATUS_OFS: begin
          state_next.rdData = {5'h00, state_reg.evtStatus};
        end
        `IRQ_EVT_MASK_OFS: begin
          state_next.rdData = {5'h00, state_reg.evtMask};
        end
        default: begin
          state_next.rdData = 8'h00;  // Unmapped offsets read zero
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Synchronous reset; flags, enables and code take their documented values
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign busRdData       = state_reg.rdData;
  assign cpuIntLevelZero = state_reg.cpuInt[0];  // cpuInt is indexed by processor level
  assign cpuIntLevelOne  = state_reg.cpuInt[1];
  assign cpuIntLevelTwo  = state_reg.cpuInt[2];
  assign irqOut          = state_reg.irqOut;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cbAssert @(posedge sys_clk);
  endclocking

  // Reset clears flags, enables and summary and parks the code at all ones
  a_reset_values: assert property (
    rst |=> (state_reg.flags == 24'h000000) && (state_reg.topCode == 8'hFF)
            && (state_reg.enables == 24'h000000) && (state_reg.summary == 3'h0))
  else $error("reset did not clear flags, enables, summary or code");

  // An enabled rising edge is memorised at the next edge
  a_edge_sets_flag: assert property (
    disable iff (rst)
    (setVec != 24'h000000) |=> ((state_reg.flags & $past(setVec)) == $past(setVec)))
  else $error("enabled rising edge did not set its flag");

  // No flag rises without an enabled edge behind it
  a_no_spurious_flag: assert property (
    disable iff (rst)
    ##1 ((state_reg.flags & ~$past(state_reg.flags) & ~$past(setVec)) == 24'h000000))
  else $error("flag set without an enabled rising edge");

  // Ones written to the high flags clear those bits unless an edge returns
  a_high_w1c: assert property (
    disable iff (rst)
    hit(busReq, `IRQ_HIGH_FLAGS_OFS, 1'b1) && (setVec[23:16] == 8'h00)
      |=> ((state_reg.flags[23:16] & $past(busReq.wrData)) == 8'h00))
  else $error("write of one did not clear high flag");

  // Zero bits of a low flag write leave the low flags as they were
  a_zero_keeps: assert property (
    disable iff (rst)
    hit(busReq, `IRQ_LOW_FLAGS_OFS, 1'b1)
      |=> ((state_reg.flags[7:0] & ~$past(busReq.wrData))
           == ($past(state_reg.flags[7:0]) & ~$past(busReq.wrData)))
          || ($past(setVec[7:0]) != 8'h00))
  else $error("write of zero changed a low flag");

  // High group source edge raises level zero exactly one cycle later
  a_level_latency: assert property (
    disable iff (rst)
    (setVec[23:16] != 8'h00) |=> cpuIntLevelZero ##1 (cpuIntLevelZero
                                 || $past(clrVec[23:16]) != 8'h00))
  else $error("level zero did not follow a high group edge");

  // Each level tracks its group and the summary tracks the same groups
  a_level_holds: assert property (
    disable iff (rst)
    (cpuIntLevelZero == (|state_reg.flags[23:16]))
    && (cpuIntLevelOne == (|state_reg.flags[15:8]))
    && (cpuIntLevelTwo == (|state_reg.flags[7:0]))
    && (state_reg.summary == {cpuIntLevelZero, cpuIntLevelOne, cpuIntLevelTwo}))
  else $error("processor level or summary out of step with flags");

  // Idle code whenever nothing is pending
  a_idle_code: assert property (
    disable iff (rst)
    (state_reg.flags == 24'h000000) |-> (state_reg.topCode == 8'hFF))
  else $error("top code not 0xFF with no flag pending");

  // Code names the highest pending source and nothing above it is set
  a_top_code: assert property (
    disable iff (rst)
    (state_reg.flags != 24'h000000)
      |-> (state_reg.topCode < 8'd24)
          && ((state_reg.flags >> state_reg.topCode) == 24'h000001))
  else $error("top code is not the highest pending source");

  // Summary read shows zeros above the three level bits
  a_summary_read: assert property (
    disable iff (rst)
    hit(busReq, `IRQ_SUMMARY_OFS, 1'b0)
      |=> (busRdData == {5'h00, $past(state_reg.summary)}))
  else $error("summary read returned wrong value");

  // Enable write reads back unchanged
  a_enable_rw: assert property (
    disable iff (rst)
    hit(busReq, `IRQ_MID_EN_OFS, 1'b1)
      |=> (state_reg.enables[15:8] == $past(busReq.wrData)))
  else $error("mid enable write not stored");

  // Interrupt output follows masked sticky events
  a_irq_out: assert property (
    disable iff (rst)
    irqOut == (|(state_reg.evtStatus & state_reg.evtMask)))
  else $error("interrupt output disagrees with status and mask");

  // Top code read returns the registered code in the next cycle
  a_code_read: assert property (
    disable iff (rst)
    hit(busReq, `IRQ_TOP_CODE_OFS, 1'b0)
      |=> (busRdData == $past(state_reg.topCode)))
  else $error("top code read returned wrong value");

  // Ones written to the mid flags clear those bits unless an edge returns
  a_mid_w1c: assert property (
    disable iff (rst)
    hit(busReq, `IRQ_MID_FLAGS_OFS, 1'b1) && (setVec[15:8] == 8'h00)
      |=> ((state_reg.flags[15:8] & $past(busReq.wrData)) == 8'h00))
  else $error("write of one did not clear mid flag");

  // Ones written to the low flags clear those bits unless an edge returns
  a_low_w1c: assert property (
    disable iff (rst)
    hit(busReq, `IRQ_LOW_FLAGS_OFS, 1'b1) && (setVec[7:0] == 8'h00)
      |=> ((state_reg.flags[7:0] & $past(busReq.wrData)) == 8'h00))
  else $error("write of one did not clear low flag");

  // Read data fall back to zero outside a read cycle, so software
  // polling a stale bus value can never mistake it for fresh data
  a_read_idle: assert property (
    disable iff (rst)
    !busReq.rd |=> (busRdData == 8'h00))
  else $error("read data not zero outside a read cycle");

  // Mid group edge raises level one at the next edge; the set path
  // beats a same-cycle clear, so no write can hide the new request
  a_level_one_rise: assert property (
    disable iff (rst)
    (setVec[15:8] != 8'h00) |=> cpuIntLevelOne)
  else $error("level one did not follow a mid group edge");

  // Low group edge raises level two at the next edge; same reasoning
  // as for level one, the lowest group must not be starved of latency
  a_level_two_rise: assert property (
    disable iff (rst)
    (setVec[7:0] != 8'h00) |=> cpuIntLevelTwo)
  else $error("level two did not follow a low group edge");

  // High enable write reads back unchanged
  a_high_en_rw: assert property (
    disable iff (rst)
    hit(busReq, `IRQ_HIGH_EN_OFS, 1'b1)
      |=> (state_reg.enables[23:16] == $past(busReq.wrData)))
  else $error("high enable write not stored");

  // Low enable write reads back unchanged
  a_low_en_rw: assert property (
    disable iff (rst)
    hit(busReq, `IRQ_LOW_EN_OFS, 1'b1)
      |=> (state_reg.enables[7:0] == $past(busReq.wrData)))
  else $error("low enable write not stored");

endmodule

/* verilog/irq_defs.svh */
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define IRQ_ADDR_W        4
`define IRQ_DATA_W        8
`define IRQ_GROUP_W       8
`define IRQ_LEVELS        3
`define IRQ_SOURCES       24

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define IRQ_HIGH_FLAGS_OFS    4'h0
`define IRQ_MID_FLAGS_OFS     4'h1
`define IRQ_LOW_FLAGS_OFS     4'h2
`define IRQ_HIGH_EN_OFS       4'h3
`define IRQ_MID_EN_OFS        4'h4
`define IRQ_LOW_EN_OFS        4'h5
`define IRQ_TOP_CODE_OFS      4'h6
`define IRQ_SUMMARY_OFS       4'h7
`define IRQ_EVT_STATUS_OFS    4'h8
`define IRQ_EVT_MASK_OFS      4'h9

// ----------------------------------------------------------------------
// Field positions: first source number of each group, summary bits
// ----------------------------------------------------------------------
`define IRQ_HIGH_BASE     16
`define IRQ_MID_BASE      8
`define IRQ_LOW_BASE      0
`define IRQ_SUM_HIGH_BIT  2
`define IRQ_SUM_MID_BIT   1
`define IRQ_SUM_LOW_BIT   0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IRQ_FLAGS_RST     24'h000000
`define IRQ_EN_RST        24'h000000
`define IRQ_CODE_RST      8'hFF
`define IRQ_NONE_CODE     8'hFF
`define IRQ_SUM_RST       3'h0
`define IRQ_EVT_RST       3'h0
`define IRQ_RD_RST        8'h00

`endif

/* verilog/irq_pkg.sv */
`include "irq_defs.svh"

package irq_pkg;

  typedef logic [`IRQ_SOURCES-1:0] src_vec_t;
  typedef logic [`IRQ_LEVELS-1:0]  level_vec_t;
  typedef logic [`IRQ_DATA_W-1:0]  byte_t;
  typedef logic [`IRQ_ADDR_W-1:0]  addr_t;

  // Register port request, one cycle per access
  typedef struct packed {
    addr_t addr;
    byte_t wrData;
    logic  wr;
    logic  rd;
  } bus_req_t;

  // Whole state of the handler
  typedef struct packed {
    src_vec_t   flags;
    src_vec_t   enables;
    src_vec_t   srcPrev;
    byte_t      topCode;
    level_vec_t summary;
    level_vec_t cpuInt;
    level_vec_t evtStatus;
    level_vec_t evtMask;
    logic       irqOut;
    byte_t      rdData;
  } state_t;

endpackage

/* verilog/pending_code_encoder.sv */
`timescale 1ns/1ps
`include "irq_defs.svh"

// Highest set bit wins; no bit set gives the idle code
module pending_code_encoder #(
  parameter int WIDTH = `IRQ_SOURCES
) (
  input  wire logic [WIDTH-1:0] pending,
  output logic [7:0]            code
);

  // ----------------------------------------------------------------------
  // Ascending scan, later hits overwrite earlier ones
  // ----------------------------------------------------------------------
  always_comb begin
    code = `IRQ_NONE_CODE;
    for (int i = 0; i < WIDTH; i++) begin
      if (pending[i]) begin
        code = 8'(i);
      end
    end
  end

endmodule

/* verif/cpu_core_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Processor side of the three interrupt levels
// ----------------------------------------------------------------------
module cpu_core_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       levelZero,
  input  wire logic       levelOne,
  input  wire logic       levelTwo,
  output logic [1:0]      servedLevel
);
  // Level zero wins over one, one over two; 3 means nothing to serve
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      servedLevel <= 2'h3;
    end else if (levelZero) begin
      servedLevel <= 2'h0;
    end else if (levelOne) begin
      servedLevel <= 2'h1;
    end else if (levelTwo) begin
      servedLevel <= 2'h2;
    end else begin
      servedLevel <= 2'h3;
    end
  end
endmodule

/* verif/three_level_irq_handler_test.sv */
`timescale 1ns/1ps
`include "irq_defs.svh"

module three_level_irq_handler_test;
  logic              sys_clk;
  logic              rst;
  irq_pkg::src_vec_t srcIn;
  irq_pkg::bus_req_t busReq;
  logic [7:0]        busRdData;
  logic              lvZero;
  logic              lvOne;
  logic              lvTwo;
  logic              irqOut;
  logic [1:0]        served;
  int                failures;
  int                n_compared;

  three_level_irq_handler dut (.sys_clk(sys_clk), .rst(rst), .srcIn(srcIn), .busReq(busReq),
    .busRdData(busRdData), .cpuIntLevelZero(lvZero), .cpuIntLevelOne(lvOne),
    .cpuIntLevelTwo(lvTwo), .irqOut(irqOut));
  cpu_core_model core (.sys_clk(sys_clk), .rst(rst), .levelZero(lvZero), .levelOne(lvOne),
    .levelTwo(lvTwo), .servedLevel(served));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe, released at the edge that takes it
  task automatic wr(input irq_pkg::addr_t a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    busReq <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input string what, input irq_pkg::addr_t a, input logic [7:0] exp);
    @(posedge sys_clk);
    busReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    busReq <= '0;
    #1;
    chk(what, busRdData, exp);
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // A hang counts as a mismatch and still reaches the verdict
  initial begin
    for (int i = 0; i < 100000; i++) @(posedge sys_clk);
    failures++;
    $display("FAIL watchdog expected end seen hang");
    complete_run();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0] bitv;
    int         g;
    failures = 0;
    n_compared = 0;
    rst = 1'b1;
    srcIn = '0;
    busReq = '0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values; 0xA is unmapped and reads zero
    for (int a = 0; a < 11; a++) begin
      rdchk("reset value", 4'(a), (a == 6) ? 8'hFF : 8'h00);
    end
    $display("test reset_values done");
    // Enables are read-write; code, summary and unmapped places ignore writes
    wr(`IRQ_HIGH_EN_OFS, 8'h5A);
    wr(`IRQ_MID_EN_OFS, 8'hA5);
    wr(`IRQ_LOW_EN_OFS, 8'h3C);
    wr(`IRQ_TOP_CODE_OFS, 8'h00);
    wr(`IRQ_SUMMARY_OFS, 8'hFF);
    wr(4'hA, 8'hFF);
    rdchk("high enables", `IRQ_HIGH_EN_OFS, 8'h5A);
    rdchk("mid enables", `IRQ_MID_EN_OFS, 8'hA5);
    rdchk("low enables", `IRQ_LOW_EN_OFS, 8'h3C);
    rdchk("code read only", `IRQ_TOP_CODE_OFS, 8'hFF);
    rdchk("summary read only", `IRQ_SUMMARY_OFS, 8'h00);
    rdchk("unmapped", 4'hA, 8'h00);
    $display("test register_access done");
    // Every source alone: position, latency, level, code, clearing
    wr(`IRQ_HIGH_EN_OFS, 8'hFF);
    wr(`IRQ_MID_EN_OFS, 8'hFF);
    wr(`IRQ_LOW_EN_OFS, 8'hFF);
    for (int n = 0; n < 24; n++) begin
      g = n / 8;
      bitv = 8'h01 << (n % 8);
      @(posedge sys_clk);
      srcIn[n] <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk("level after edge", {5'h00, lvZero, lvOne, lvTwo}, 8'h01 << g);
      rdchk("flag position", 4'(2 - g), bitv);
      rdchk("top code", `IRQ_TOP_CODE_OFS, 8'(n));
      rdchk("summary", `IRQ_SUMMARY_OFS, 8'h01 << g);
      wr(4'(2 - g), ~bitv);
      rdchk("zero write keeps", 4'(2 - g), bitv);
      chk("level held", {5'h00, lvZero, lvOne, lvTwo}, 8'h01 << g);
      wr(4'(2 - g), bitv);
      rdchk("one write clears", 4'(2 - g), 8'h00);
      chk("level dropped", {5'h00, lvZero, lvOne, lvTwo}, 8'h00);
      rdchk("idle code", `IRQ_TOP_CODE_OFS, 8'hFF);
      @(posedge sys_clk);
      srcIn[n] <= 1'b0;
    end
    $display("test each_source done");
    // Three groups at once: ranking and order of service
    @(posedge sys_clk);
    srcIn <= 24'h201008;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("served first", {6'h00, served}, 8'h00);
    rdchk("code of three", `IRQ_TOP_CODE_OFS, 8'd21);
    wr(`IRQ_HIGH_FLAGS_OFS, 8'h20);
    rdchk("code of two", `IRQ_TOP_CODE_OFS, 8'd12);
    chk("served second", {6'h00, served}, 8'h01);
    wr(`IRQ_MID_FLAGS_OFS, 8'h10);
    rdchk("code of one", `IRQ_TOP_CODE_OFS, 8'd3);
    chk("served third", {6'h00, served}, 8'h02);
    wr(`IRQ_LOW_FLAGS_OFS, 8'h08);
    rdchk("code of none", `IRQ_TOP_CODE_OFS, 8'hFF);
    @(posedge sys_clk);
    srcIn <= '0;
    $display("test priority done");
    // Disabled edge is not remembered, a held level never retriggers
    wr(`IRQ_LOW_EN_OFS, 8'h00);
    @(posedge sys_clk);
    srcIn[2] <= 1'b1;
    rdchk("disabled edge", `IRQ_LOW_FLAGS_OFS, 8'h00);
    wr(`IRQ_LOW_EN_OFS, 8'h04);
    rdchk("held level", `IRQ_LOW_FLAGS_OFS, 8'h00);
    @(posedge sys_clk);
    srcIn[2] <= 1'b0;
    @(posedge sys_clk);
    srcIn[2] <= 1'b1;
    rdchk("fresh edge", `IRQ_LOW_FLAGS_OFS, 8'h04);
    $display("test enable_gate done");
    // Group event: raised, masked, cleared
    wr(`IRQ_EVT_STATUS_OFS, 8'h07);
    wr(`IRQ_EVT_MASK_OFS, 8'h07);
    @(posedge sys_clk);
    srcIn[9] <= 1'b1;
    rdchk("event status", `IRQ_EVT_STATUS_OFS, 8'h02);
    chk("irq raised", {7'h00, irqOut}, 8'h01);
    wr(`IRQ_EVT_MASK_OFS, 8'h05);
    rdchk("event mask", `IRQ_EVT_MASK_OFS, 8'h05);
    chk("irq masked", {7'h00, irqOut}, 8'h00);
    wr(`IRQ_EVT_MASK_OFS, 8'h07);
    wr(`IRQ_EVT_STATUS_OFS, 8'h02);
    rdchk("event cleared", `IRQ_EVT_STATUS_OFS, 8'h00);
    chk("irq cleared", {7'h00, irqOut}, 8'h00);
    $display("test event_irq done");
    // Reset in mid-run drops pending flags and enables
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk("flags after reset", `IRQ_MID_FLAGS_OFS, 8'h00);
    rdchk("low after reset", `IRQ_LOW_FLAGS_OFS, 8'h00);
    rdchk("enables after reset", `IRQ_MID_EN_OFS, 8'h00);
    chk("levels after reset", {5'h00, lvZero, lvOne, lvTwo}, 8'h00);
    $display("test second_reset done");
    complete_run();
  end
endmodule
